/* File: rtl/adc_seq_pkg.sv */
// package: register map, field layout and types for the adc sequencing control
package adc_seq_pkg;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  OFF_CTRL_TWO  = 4'h0;
    localparam logic [3:0]  OFF_MODE      = 4'h1;
    localparam logic [3:0]  OFF_STATUS    = 4'h2;
    localparam logic [3:0]  OFF_IRQ_STAT  = 4'h3;
    localparam logic [3:0]  OFF_IRQ_MASK  = 4'h4;
    localparam logic [3:0]  OFF_SCAN_SEL  = 4'h5;
    localparam logic [3:0]  OFF_SLOT      = 4'h6;

    localparam int          BIT_ALTERNATE_SAMPLE_MODE      = 0;
    localparam int          BIT_SPLIT_BUFFER_MODE      = 1;
    localparam int          BIT_RATE_LO   = 2;
    localparam int          BIT_BUFFER_HALF_STATUS      = 7;
    localparam int          BIT_CH_LO     = 8;
    localparam int          BIT_SCAN      = 10;
    localparam int          BIT_REF_LO    = 13;

    localparam logic [15:0] CTRL_TWO_RST  = 16'h0000;
    localparam logic [15:0] CTRL_TWO_WMSK = 16'he77f;
    localparam logic [1:0]  MODE_RST      = 2'h0;
    localparam logic [15:0] SCAN_RST      = 16'h0000;
    localparam logic [2:0]  IRQ_RST       = 3'h0;
    localparam logic [4:0]  RATE_NODMA_MAX = 5'h0f;

    // interrupt events: conversion group done, dma step, buffer half swap
    localparam int          EV_CONV       = 0;
    localparam int          EV_DMA        = 1;
    localparam int          EV_HALF       = 2;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic        alt_b;
        logic [1:0]  ch_count;
        logic        scanning;
        logic [3:0]  ch0_input;
        logic        upper_half;
        logic [5:0]  buf_index;
    } seq_out_t;
endpackage

/* File: rtl/rate_counter.sv */
// counts completed operations and pulses on every (n+1)-th one
`timescale 1ns/100ps
`default_nettype none
module rate_counter #(
    parameter int W = 5
) (
    input  wire logic         clk,        // clock
    input  wire logic         sys_rst,    // sync reset
    input  wire logic         clr,        // restart count
    input  wire logic         done,       // one operation completed
    input  wire logic [W-1:0] limit,      // n, pulse after n+1
    output logic              hit         // one-cycle pulse
);
    logic [W-1:0] cnt_ff;
    wire          at_limit = (cnt_ff >= limit);

    assign hit = done & at_limit;

    always_ff @(posedge clk) begin
        if (sys_rst || clr || hit) begin
            cnt_ff <= '0;
        end else if (done) begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/scan_picker.sv */
// finds the next selected scan input after the current one, wrapping
`timescale 1ns/100ps
`default_nettype none
module scan_picker #(
    parameter int N = 16
) (
    input  wire logic [N-1:0]         sel,     // scan selection mask
    input  wire logic [$clog2(N)-1:0] cur,     // current input
    output logic [$clog2(N)-1:0]      nxt,     // next selected input
    output logic                      any      // mask non-empty
);
    localparam int IW = $clog2(N);

    assign any = |sel;

    always_comb begin
        logic [IW-1:0] cand;
        logic          found;
        cand  = '0;
        nxt   = cur;
        found = 1'b0;
        for (int k = 1; k <= N; k++) begin
            cand = IW'((int'(cur) + k) % N);
            if (!found && sel[cand]) begin
                nxt   = cand;
                found = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/adc_sequence_buffer_control.sv */
// adc second control register and conversion sequencing control
`timescale 1ns/100ps
`default_nettype none
// Function
// - scan enable steps primary input through selection
// - channel count picks one, two or four
// - twelve-bit mode: channel count reads zero
// - split mode alternates halves per interrupt
// - no split: restart at start each interrupt
// - alternate mode swaps input sets per sample
// - alternate off: always first input set
module adc_sequence_buffer_control #(
    parameter int SCAN_N = 16,
    parameter int BUF_W  = 6
) (
    input  wire logic                  clk,           // 200 mhz clock
    input  wire logic                  sys_rst,       // sync reset, high
    input  wire logic [3:0]            reg_addr,      // register index
    input  wire logic [15:0]           reg_wdata,     // write data
    input  wire logic                  reg_wr,        // write strobe
    input  wire logic                  reg_rd,        // read strobe
    output logic [15:0]                reg_rdata,     // read data, next cycle
    input  wire logic                  conv_done,     // one sample/conversion done
    output adc_seq_pkg::seq_out_t      seq,           // sequencing state
    output logic                       conv_irq,      // conversion interrupt pulse
    output logic                       dma_step,      // dma address step pulse
    output logic                       irq            // level interrupt
);
    localparam int IW = $clog2(SCAN_N);

    adc_seq_pkg::bus_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [15:0]        ctrl_ff;
    logic [1:0]         mode_ff;      // [0] twelve_bit_select, [1] dma_path_enable
    logic [15:0]        scan_ff;
    logic [2:0]         irq_stat_ff;
    logic [2:0]         irq_mask_ff;
    logic [15:0]        rdata_ff;
    logic               upper_ff;
    logic               alt_b_ff;
    logic [IW-1:0]      ch0_ff;
    logic [BUF_W-1:0]   idx_ff;

    wire twelve_bit     = mode_ff[0];
    wire dma_en         = mode_ff[1];
    wire alternate_sample_mode           = ctrl_ff[adc_seq_pkg::BIT_ALTERNATE_SAMPLE_MODE];
    wire split_buffer_mode           = ctrl_ff[adc_seq_pkg::BIT_SPLIT_BUFFER_MODE];
    wire scan_en        = ctrl_ff[adc_seq_pkg::BIT_SCAN];
    wire [4:0] rate_raw = ctrl_ff[adc_seq_pkg::BIT_RATE_LO +: 5];
    wire [1:0] ch_raw   = ctrl_ff[adc_seq_pkg::BIT_CH_LO +: 2];

    function automatic logic hit_addr(input logic [3:0] a, input logic [3:0] off);
        hit_addr = (a == off);
    endfunction

    wire wr_ctrl  = req.wr & hit_addr(req.addr, adc_seq_pkg::OFF_CTRL_TWO);
    wire wr_mode  = req.wr & hit_addr(req.addr, adc_seq_pkg::OFF_MODE);
    wire wr_stat  = req.wr & hit_addr(req.addr, adc_seq_pkg::OFF_IRQ_STAT);
    wire wr_mask  = req.wr & hit_addr(req.addr, adc_seq_pkg::OFF_IRQ_MASK);
    wire wr_scan  = req.wr & hit_addr(req.addr, adc_seq_pkg::OFF_SCAN_SEL);

    // twelve-bit mode holds the channel count at zero
    wire [1:0] ch_eff = twelve_bit ? 2'h0 : ch_raw;

    // without dma only n up to fifteen applies
    wire [4:0] rate_eff = (!dma_en && rate_raw > adc_seq_pkg::RATE_NODMA_MAX)
                          ? adc_seq_pkg::RATE_NODMA_MAX : rate_raw;

    logic group_hit;
    rate_counter #(.W(5)) u_rate (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clr     (wr_ctrl | wr_mode),
        .done    (conv_done),
        .limit   (rate_eff),
        .hit     (group_hit)
    );

    assign conv_irq = group_hit & ~dma_en;
    assign dma_step = group_hit & dma_en;

    logic [IW-1:0] scan_next;
    logic          scan_any;
    scan_picker #(.N(SCAN_N)) u_scan (
        .sel (scan_ff[SCAN_N-1:0]),
        .cur (ch0_ff),
        .nxt (scan_next),
        .any (scan_any)
    );

    // control register: writable fields, twelve-bit clears channel count
    wire [15:0] ctrl_wr_val = req.wdata & adc_seq_pkg::CTRL_TWO_WMSK;
    wire [15:0] nxt_ctrl    = twelve_bit
                              ? {ctrl_wr_val[15:10], 2'h0, ctrl_wr_val[7:0]}
                              : ctrl_wr_val;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff <= adc_seq_pkg::CTRL_TWO_RST;
            mode_ff <= adc_seq_pkg::MODE_RST;
            scan_ff <= adc_seq_pkg::SCAN_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= nxt_ctrl;
            end
            if (wr_mode) begin
                mode_ff <= req.wdata[1:0];
            end
            if (wr_scan) begin
                scan_ff <= req.wdata;
            end
        end
    end

    // input set selection per sample
    wire nxt_alt_b = alternate_sample_mode ? ~alt_b_ff : 1'b0;

    // primary input: step through scan list on first-set samples only
    wire scan_step = scan_en & scan_any & ~alt_b_ff;

    // buffer half: toggles on interrupt in split mode, else stays lower
    wire half_flip  = conv_irq & split_buffer_mode;
    wire nxt_upper  = split_buffer_mode ? (upper_ff ^ half_flip) : 1'b0;

    // write index: restart at the half start on interrupt
    wire [BUF_W-1:0] half_base = nxt_upper ? BUF_W'(1 << (BUF_W-1)) : '0;
    wire [BUF_W-1:0] nxt_idx   = conv_irq ? half_base
                                 : (idx_ff + BUF_W'(1));

    always_ff @(posedge clk) begin
        if (sys_rst || wr_ctrl) begin
            upper_ff <= 1'b0;
            alt_b_ff <= 1'b0;
            idx_ff   <= '0;
            ch0_ff   <= '0;
        end else if (conv_done) begin
            upper_ff <= nxt_upper;
            alt_b_ff <= nxt_alt_b;
            idx_ff   <= nxt_idx;
            if (scan_step) begin
                ch0_ff <= scan_next;
            end
        end
    end

    assign seq = '{alt_b: alt_b_ff, ch_count: ch_eff, scanning: scan_en,
                   ch0_input: 4'(ch0_ff), upper_half: upper_ff,
                   buf_index: 6'(idx_ff)};

    // interrupt status: set wins over write-one-to-clear
    wire [2:0] ev = {half_flip, dma_step, conv_irq};
    wire [2:0] clr_bits = wr_stat ? req.wdata[2:0] : 3'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_ff <= adc_seq_pkg::IRQ_RST;
            irq_mask_ff <= adc_seq_pkg::IRQ_RST;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~clr_bits) | ev;
            if (wr_mask) begin
                irq_mask_ff <= req.wdata[2:0];
            end
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // read view: half flag is live, channel count forced in twelve-bit mode
    wire [15:0] ctrl_view = {ctrl_ff[15:10], ch_eff, upper_ff, ctrl_ff[6:0]};

    logic [15:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            adc_seq_pkg::OFF_CTRL_TWO: rd_mux = ctrl_view;
            adc_seq_pkg::OFF_MODE:     rd_mux = {14'h0, mode_ff};
            adc_seq_pkg::OFF_STATUS:   rd_mux = {9'h0, idx_ff & {BUF_W{1'b1}}, alt_b_ff};
            adc_seq_pkg::OFF_IRQ_STAT: rd_mux = {13'h0, irq_stat_ff};
            adc_seq_pkg::OFF_IRQ_MASK: rd_mux = {13'h0, irq_mask_ff};
            adc_seq_pkg::OFF_SCAN_SEL: rd_mux = scan_ff;
            adc_seq_pkg::OFF_SLOT:     rd_mux = {12'h0, 4'(ch0_ff)};
            default:                   rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= 16'h0000;
        end else if (req.rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

/* File: tb/adc_seq_checker_properties.sv */
// checker: port-level properties of the adc sequencing control
`timescale 1ns/100ps
`default_nettype none
module adc_seq_checker (
    input wire logic                  clk,       // clock
    input wire logic                  sys_rst,   // sync reset
    input wire logic [3:0]            reg_addr,  // index
    input wire logic [15:0]           reg_wdata, // write data
    input wire logic                  reg_wr,    // write strobe
    input wire logic                  reg_rd,    // read strobe
    input wire logic [15:0]           reg_rdata, // read data
    input wire logic                  conv_done, // op done
    input wire adc_seq_pkg::seq_out_t seq,       // state
    input wire logic                  conv_irq,  // irq pulse
    input wire logic                  dma_step,  // dma pulse
    input wire logic                  irq        // level irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence wr_prev;
        $past(reg_wr);
    endsequence
    sequence op_prev;
        $past(conv_done) || $past(reg_wr);
    endsequence
    chk_pulse_excl: assert property (!(conv_irq && dma_step))
        else $error("irq and dma pulses together");
    chk_irq_cause: assert property (conv_irq |-> conv_done)
        else $error("irq pulse without completed op");
    chk_dma_cause: assert property (dma_step |-> conv_done)
        else $error("dma step without completed op");
    chk_half_cause: assert property ($changed(seq.upper_half) |-> $past(conv_irq || dma_step || reg_wr))
        else $error("half flag moved without group end");
    chk_alt_cause: assert property ($changed(seq.alt_b) |-> op_prev)
        else $error("input set moved without sample");
    chk_scan_step: assert property ($changed(seq.ch0_input) |-> op_prev)
        else $error("primary input moved without sample");
    chk_scan_flag: assert property ($changed(seq.scanning) |-> wr_prev)
        else $error("scan flag moved without write");
    chk_count_hold: assert property ($changed(seq.ch_count) |-> wr_prev)
        else $error("channel count moved without write");
    chk_rdata_slot: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
        else $error("read data outside its slot");
    chk_irq_rise: assert property ($rose(irq) |-> $past(conv_irq || dma_step || reg_wr))
        else $error("interrupt rose without cause");
endmodule
bind adc_sequence_buffer_control adc_seq_checker chk_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .conv_done, .seq, .conv_irq, .dma_step, .irq);
`default_nettype wire

/* File: tb/adc_sequence_buffer_control_tb_top.sv */
// testbench: registers, rates, buffer halves, alternation and scan
`timescale 1ns/100ps
`default_nettype none
module adc_sequence_buffer_control_tb_top;
    localparam logic [3:0] CT = adc_seq_pkg::OFF_CTRL_TWO;
    localparam logic [3:0] MD = adc_seq_pkg::OFF_MODE;
    localparam logic [3:0] IS = adc_seq_pkg::OFF_IRQ_STAT;
    logic clk, sys_rst, reg_wr, reg_rd, conv_done, conv_irq, dma_step, irq, rd_q;
    logic [3:0]            reg_addr;
    logic [15:0]           reg_wdata, reg_rdata;
    adc_seq_pkg::seq_out_t seq;
    logic [15:0]           rd_exp[$];
    logic [1:0]            ev_exp[$];
    int                    miscompares, samples_checked, n;
    int                    lims[5] = '{0, 1, 7, 15, 31};
    adc_sequence_buffer_control uut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .conv_done, .seq, .conv_irq, .dma_step, .irq);
    task automatic cmp(string w, logic [15:0] e, logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", w, e, s);
        end
    endtask
    task automatic cmp_rdata(logic [15:0] e, logic [15:0] s);
        cmp("rdata", e, s);
    endtask
    task automatic cmp_pulse(logic [1:0] e, logic [1:0] s);
        cmp("pulses", 16'(e), 16'(s));
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_exp.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    // random gaps between completed operations
    task automatic ops(int cnt, int lim, logic dma);
        logic b;
        int i;
        i = 0;
        while (i < cnt) begin
            b = ($urandom % 4) != 0;
            conv_done <= b;
            if (b) begin
                i++;
                ev_exp.push_back((i % (lim + 1) == 0) ? {!dma, dma} : 2'b00);
            end
            @(posedge clk);
        end
        conv_done <= 1'b0;
        @(posedge clk);
    endtask
    always @(posedge clk) rd_q <= reg_rd;
    always @(negedge clk) begin
        if (rd_q === 1'b1 && rd_exp.size() > 0) begin
            cmp_rdata(rd_exp.pop_front(), reg_rdata);
        end
        if (conv_done === 1'b1 && ev_exp.size() > 0) begin
            cmp_pulse(ev_exp.pop_front(), {conv_irq, dma_step});
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test;
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, conv_done} = 4'h8;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        miscompares = 0;
        samples_checked = 0;
        void'($urandom(92));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(CT, adc_seq_pkg::CTRL_TWO_RST);
        wr(CT, 16'hffff);
        rd(CT, 16'he77f);
        wr(MD, 16'h0001);
        wr(CT, 16'hffff);
        rd(CT, 16'he47f);
        cmp("ch_count", 16'h0000, 16'(seq.ch_count));
        rd(4'hf, 16'h0000);
        wr(MD, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            wr(CT, 16'(k) << 8);
            cmp("ch_count", 16'(k), 16'(seq.ch_count));
        end
        for (int d = 0; d < 2; d++) begin
            foreach (lims[j]) begin
                wr(MD, 16'(d << 1));
                wr(CT, 16'(lims[j]) << 2);
                n = (d == 0 && lims[j] > 15) ? 15 : lims[j];
                ops(2 * (n + 1), n, d[0]);
            end
        end
        rd(IS, 16'h0003);
        wr(MD, 16'h0000);
        wr(IS, 16'h0007);
        wr(adc_seq_pkg::OFF_IRQ_MASK, 16'h0001);
        wr(CT, 16'h0004);
        ops(2, 1, 1'b0);
        rd(IS, 16'h0001);
        cmp("irq", 16'h0001, 16'(irq));
        wr(IS, 16'h0001);
        rd(IS, 16'h0000);
        cmp("irq", 16'h0000, 16'(irq));
        wr(CT, 16'h0006);
        ops(2, 1, 1'b0);
        cmp("upper_half", 16'h0001, 16'(seq.upper_half));
        cmp("buf_index", 16'h0020, 16'(seq.buf_index));
        rd(CT, 16'h0086);
        rd(IS, 16'h0005);
        ops(2, 1, 1'b0);
        cmp("upper_half", 16'h0000, 16'(seq.upper_half));
        rd(CT, 16'h0006);
        wr(CT, 16'h0004);
        ops(2, 1, 1'b0);
        rd(CT, 16'h0004);
        rd(adc_seq_pkg::OFF_STATUS, 16'h0000);
        wr(CT, 16'h0015);
        ops(1, 5, 1'b0);
        cmp("alt_b", 16'h0001, 16'(seq.alt_b));
        cmp("buf_index", 16'h0001, 16'(seq.buf_index));
        ops(1, 5, 1'b0);
        cmp("alt_b", 16'h0000, 16'(seq.alt_b));
        wr(adc_seq_pkg::OFF_SCAN_SEL, 16'h0040);
        wr(CT, 16'h0414);
        cmp("scanning", 16'h0001, 16'(seq.scanning));
        ops(2, 5, 1'b0);
        cmp("ch0_input", 16'h0006, 16'(seq.ch0_input));
        rd(adc_seq_pkg::OFF_SLOT, 16'h0006);
        wr(CT, 16'h0014);
        ops(2, 5, 1'b0);
        cmp("ch0_input", 16'h0000, 16'(seq.ch0_input));
        finish_test;
    end
endmodule
`default_nettype wire
